/* frc_pkg.sv */
// Constants, types and parameter layout for the frequency reference combiner
package frc_pkg;
  typedef logic signed [17:0] frc_freq_t;
  typedef logic [15:0] frc_word_t;
  typedef logic [3:0] frc_idx_t;
  typedef logic [3:0] frc_code_t;

  // Parameter indices on the write/read port
  localparam frc_idx_t IDX_AUX_BASE = 4'h0;
  localparam frc_idx_t IDX_AUX_PCT = 4'h1;
  localparam frc_idx_t IDX_MAIN_COEF = 4'h2;
  localparam frc_idx_t IDX_AUX_COEF = 4'h3;
  localparam frc_idx_t IDX_MAX_FREQ = 4'h4;
  localparam frc_idx_t IDX_UPPER_SRC = 4'h5;
  localparam frc_idx_t IDX_UPPER_VAL = 4'h6;
  localparam frc_idx_t IDX_UPPER_OFS = 4'h7;
  localparam frc_idx_t IDX_LOWER_VAL = 4'h8;
  localparam frc_idx_t IDX_BELOW_ACT = 4'h9;
  localparam frc_idx_t IDX_PRESET = 4'ha;

  // Reset values and ranges, frequencies in 0.01 Hz, coefficients in 0.01 %
  localparam frc_word_t RST_BASE = 16'h0000;
  localparam frc_word_t RST_PCT = 16'h0064;
  localparam frc_word_t RST_COEF = 16'h03e8;
  localparam frc_word_t RST_MAX = 16'h1388;
  localparam frc_word_t RST_UPPER_SRC = 16'h0000;
  localparam frc_word_t RST_UPPER = 16'h1388;
  localparam frc_word_t RST_OFFSET = 16'h0000;
  localparam frc_word_t RST_LOWER = 16'h0000;
  localparam frc_word_t RST_ACTION = 16'h0000;
  localparam frc_word_t RST_PRESET = 16'h0000;
  localparam frc_word_t MAX_FREQ_LO = 16'h1388;
  localparam frc_word_t MAX_FREQ_HI = 16'hea60;
  localparam frc_word_t PCT_HI = 16'h0096;
  localparam frc_word_t COEF_HI = 16'h2710;
  localparam int PCT_SCALE = 100;
  localparam int COEF_SCALE = 10000;

  // Source codes of main and auxiliary references
  localparam frc_code_t SRC_DIG_VOLATILE = 4'h0;
  localparam frc_code_t SRC_DIG_RETAIN = 4'h1;
  localparam frc_code_t SRC_PLC = 4'h7;
  localparam frc_code_t SRC_PID = 4'h8;

  // Upper-limit source codes
  localparam frc_word_t ULS_STORED = 16'h0000;
  localparam frc_word_t ULS_AI_ONE = 16'h0001;
  localparam frc_word_t ULS_AI_TWO = 16'h0002;
  localparam frc_word_t ULS_AI_THREE = 16'h0003;
  localparam frc_word_t ULS_COMM = 16'h0005;
  localparam frc_word_t ULS_MULTI = 16'h0006;

  // Below-limit actions
  localparam frc_word_t ACT_RUN_LOWER = 16'h0000;
  localparam frc_word_t ACT_STOP = 16'h0001;
  localparam frc_word_t ACT_ZERO = 16'h0002;

  typedef enum logic [1:0] {
    REL_MAIN = 2'b00,
    REL_AUX = 2'b01,
    REL_OP = 2'b10,
    REL_SWITCH = 2'b11
  } frc_rel_t;

  typedef enum logic [2:0] {
    OP_ADD = 3'b000,
    OP_SUB = 3'b001,
    OP_MUL = 3'b010,
    OP_MAX = 3'b011,
    OP_MIN = 3'b100
  } frc_op_t;

  typedef struct packed {
    frc_word_t aux_range_base_select;
    frc_word_t aux_range_percent;
    frc_word_t main_multiply_coefficient;
    frc_word_t aux_multiply_coefficient;
    frc_word_t maximum_output_frequency;
    frc_word_t upper_limit_source_select;
    frc_word_t upper_limit_value;
    frc_word_t upper_limit_offset;
    frc_word_t lower_limit_value;
    frc_word_t below_limit_action;
    frc_word_t preset_frequency;
  } frc_params_t;
endpackage

/* frc_combiner.sv */
// Main/auxiliary reference combiner with upper and lower frequency limits
`timescale 1ns/1ps
module frc_combiner import frc_pkg::*; (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_param_wr,
  input wire frc_idx_t i_param_idx,
  input wire frc_word_t i_param_wdata,
  input wire frc_rel_t i_relationship_select,
  input wire logic [1:0] i_switch_select,
  input wire frc_op_t i_operation,
  input wire frc_code_t i_main_source,
  input wire frc_code_t i_aux_source,
  input wire frc_freq_t i_main_reference_value,
  input wire frc_freq_t i_aux_reference_value,
  input wire frc_freq_t i_updown_trim,
  input wire frc_freq_t i_pid_upper_limit,
  input wire frc_freq_t i_pid_lower_limit,
  input wire logic i_reverse_prohibit,
  input wire frc_word_t i_analog_input_one,
  input wire frc_word_t i_analog_input_two,
  input wire frc_word_t i_analog_input_three,
  input wire frc_word_t i_comm_upper_limit,
  input wire frc_word_t i_multi_upper_limit,
  output frc_freq_t o_target_frequency,
  output frc_word_t o_upper_limit_active,
  output logic o_below_lower,
  output logic o_stop_request,
  output frc_word_t o_param_rdata,
  output logic o_param_reject
);
  frc_params_t params_reg, params_next;
  logic reject_reg, reject_next;
  frc_word_t rdata_reg, rdata_next;
  frc_freq_t target_reg, target_next;
  frc_word_t upper_reg, upper_next;
  logic below_reg, below_next;
  logic stop_reg, stop_next;

  function automatic frc_word_t clampw(input frc_word_t v, input frc_word_t lo, input frc_word_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic frc_freq_t tof(input frc_word_t w);
    return $signed({2'b00, w});
  endfunction

  function automatic frc_freq_t absf(input frc_freq_t x);
    return (x < 0) ? -x : x;
  endfunction

  function automatic frc_freq_t clampf(input frc_freq_t v, input frc_freq_t lo, input frc_freq_t hi);
    return (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // Reference plus trim, held inside the limits, or zero where the held sum has the opposite sign to the reference
  function automatic frc_freq_t trimmed(input frc_freq_t base, input frc_freq_t trim,
                                        input frc_freq_t hi, input frc_freq_t lo);
    frc_freq_t s;
    s = clampf(base + trim, lo, hi);
    if ((base > 0 && s < 0) || (base < 0 && s > 0)) begin
      s = '0;
    end
    return s;
  endfunction

  // Parameter store; every limit stays inside its bounds after any write
  always_comb begin
    params_next = params_reg;
    reject_next = 1'b0;
    if (i_param_wr) begin
      case (i_param_idx)
        IDX_AUX_BASE: begin
          if (i_param_wdata <= 16'h0001) params_next.aux_range_base_select = i_param_wdata;
          else reject_next = 1'b1;
        end
        IDX_AUX_PCT: params_next.aux_range_percent = clampw(i_param_wdata, 16'h0000, PCT_HI);
        IDX_MAIN_COEF: params_next.main_multiply_coefficient = clampw(i_param_wdata, 16'h0000, COEF_HI);
        IDX_AUX_COEF: params_next.aux_multiply_coefficient = clampw(i_param_wdata, 16'h0000, COEF_HI);
        IDX_MAX_FREQ: begin
          // A lower maximum drags the dependent limits down with it
          params_next.maximum_output_frequency = clampw(i_param_wdata, MAX_FREQ_LO, MAX_FREQ_HI);
          if (params_reg.upper_limit_value > params_next.maximum_output_frequency) begin
            params_next.upper_limit_value = params_next.maximum_output_frequency;
          end
          if (params_reg.lower_limit_value > params_next.upper_limit_value) begin
            params_next.lower_limit_value = params_next.upper_limit_value;
          end
          if (params_reg.upper_limit_offset > params_next.maximum_output_frequency) begin
            params_next.upper_limit_offset = params_next.maximum_output_frequency;
          end
          if (params_reg.preset_frequency > params_next.maximum_output_frequency) begin
            params_next.preset_frequency = params_next.maximum_output_frequency;
          end
        end
        IDX_UPPER_SRC: begin
          case (i_param_wdata)
            ULS_STORED, ULS_AI_ONE, ULS_AI_TWO, ULS_AI_THREE, ULS_COMM, ULS_MULTI: begin
              params_next.upper_limit_source_select = i_param_wdata;
            end
            default: reject_next = 1'b1;
          endcase
        end
        IDX_UPPER_VAL: params_next.upper_limit_value = clampw(i_param_wdata, params_reg.lower_limit_value,
                                                              params_reg.maximum_output_frequency);
        IDX_UPPER_OFS: params_next.upper_limit_offset = clampw(i_param_wdata, 16'h0000,
                                                               params_reg.maximum_output_frequency);
        IDX_LOWER_VAL: params_next.lower_limit_value = clampw(i_param_wdata, 16'h0000,
                                                              params_reg.upper_limit_value);
        IDX_BELOW_ACT: begin
          if (i_param_wdata <= ACT_ZERO) params_next.below_limit_action = i_param_wdata;
          else reject_next = 1'b1;
        end
        IDX_PRESET: params_next.preset_frequency = clampw(i_param_wdata, 16'h0000,
                                                          params_reg.maximum_output_frequency);
        default: reject_next = 1'b1;
      endcase
    end
    case (i_param_idx)
      IDX_AUX_BASE: rdata_next = params_reg.aux_range_base_select;
      IDX_AUX_PCT: rdata_next = params_reg.aux_range_percent;
      IDX_MAIN_COEF: rdata_next = params_reg.main_multiply_coefficient;
      IDX_AUX_COEF: rdata_next = params_reg.aux_multiply_coefficient;
      IDX_MAX_FREQ: rdata_next = params_reg.maximum_output_frequency;
      IDX_UPPER_SRC: rdata_next = params_reg.upper_limit_source_select;
      IDX_UPPER_VAL: rdata_next = params_reg.upper_limit_value;
      IDX_UPPER_OFS: rdata_next = params_reg.upper_limit_offset;
      IDX_LOWER_VAL: rdata_next = params_reg.lower_limit_value;
      IDX_BELOW_ACT: rdata_next = params_reg.below_limit_action;
      IDX_PRESET: rdata_next = params_reg.preset_frequency;
      default: rdata_next = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      params_reg <= '{RST_BASE, RST_PCT, RST_COEF, RST_COEF, RST_MAX, RST_UPPER_SRC,
                      RST_UPPER, RST_OFFSET, RST_LOWER, RST_ACTION, RST_PRESET};
      reject_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      params_reg <= params_next;
      reject_reg <= reject_next;
      rdata_reg <= rdata_next;
    end
  end

  // Combining datapath
  frc_rel_t rel_eff;
  logic m_dig, a_dig, m_pid, a_pid, m_bad, a_bad, sel_pid, pid_mode;
  frc_freq_t max_f, lower_f, preset_f, upper_raw, upper_f, pid_lo_eff;
  frc_freq_t mv, av, aux_rng, aux_lim, op_val, sel_val, raw, mag;
  logic signed [39:0] mul_m, mul_a, mul_p;

  always_comb begin
    max_f = tof(params_reg.maximum_output_frequency);
    lower_f = tof(params_reg.lower_limit_value);
    preset_f = tof(params_reg.preset_frequency);
    case (params_reg.upper_limit_source_select)
      ULS_AI_ONE: upper_raw = tof(i_analog_input_one) + tof(params_reg.upper_limit_offset);
      ULS_AI_TWO: upper_raw = tof(i_analog_input_two) + tof(params_reg.upper_limit_offset);
      ULS_AI_THREE: upper_raw = tof(i_analog_input_three) + tof(params_reg.upper_limit_offset);
      ULS_COMM: upper_raw = tof(i_comm_upper_limit);
      ULS_MULTI: upper_raw = tof(i_multi_upper_limit);
      default: upper_raw = tof(params_reg.upper_limit_value);
    endcase
    upper_f = clampf(upper_raw, 18'sh00000, max_f);
    rel_eff = (i_relationship_select == REL_SWITCH) ?
              ((i_switch_select == 2'b11) ? REL_OP : frc_rel_t'(i_switch_select)) : i_relationship_select;
    m_dig = (i_main_source == SRC_DIG_VOLATILE) || (i_main_source == SRC_DIG_RETAIN);
    a_dig = (i_aux_source == SRC_DIG_VOLATILE) || (i_aux_source == SRC_DIG_RETAIN);
    m_pid = (i_main_source == SRC_PID);
    a_pid = (i_aux_source == SRC_PID);
    m_bad = m_pid || (i_main_source == SRC_PLC);
    a_bad = a_pid || (i_aux_source == SRC_PLC);
    mv = m_dig ? preset_f : i_main_reference_value;
    av = a_dig ? preset_f : i_aux_reference_value;
    pid_lo_eff = (i_reverse_prohibit && i_pid_lower_limit < 0) ? 18'sh00000 : i_pid_lower_limit;
    // Aux range base: maximum frequency or main reference magnitude
    aux_rng = frc_freq_t'(((params_reg.aux_range_base_select == 16'h0000) ? 32'(max_f) : 32'(absf(mv)))
                          * 32'(params_reg.aux_range_percent) / PCT_SCALE);
    aux_lim = clampf(av, -aux_rng, aux_rng);
    // Product normalised to maximum frequency to stay in frequency units
    mul_m = 40'(mv) * $signed({1'b0, params_reg.main_multiply_coefficient}) / COEF_SCALE;
    mul_a = 40'(av) * $signed({1'b0, params_reg.aux_multiply_coefficient}) / COEF_SCALE;
    mul_p = mul_m * mul_a / $signed({24'h000000, params_reg.maximum_output_frequency});
    if (mul_p > 40'(max_f)) mul_p = 40'(max_f);
    if (mul_p < -40'(max_f)) mul_p = -40'(max_f);
    if (i_operation == OP_ADD) begin
      if (m_pid && !a_dig && !a_pid) op_val = aux_lim;
      else if (m_dig && a_dig) op_val = trimmed(preset_f, i_updown_trim, upper_f, lower_f);
      else if (m_pid && a_dig) op_val = i_main_reference_value;
      else if (a_dig) op_val = trimmed(i_main_reference_value, i_updown_trim, upper_f, lower_f);
      else op_val = mv + aux_lim;
    end else if (m_dig && a_dig) begin
      op_val = trimmed(preset_f, i_updown_trim, upper_f, lower_f);
    end else if (m_bad && a_bad) begin
      op_val = '0;
    end else if (m_bad) begin
      op_val = av;
    end else if (a_bad) begin
      op_val = mv;
    end else begin
      case (i_operation)
        OP_SUB: op_val = mv - av;
        OP_MUL: op_val = frc_freq_t'(mul_p);
        OP_MAX: op_val = (mv > av) ? mv : av;
        OP_MIN: op_val = (mv < av) ? mv : av;
        default: op_val = mv;
      endcase
    end
    sel_pid = (rel_eff == REL_AUX) ? a_pid : m_pid;
    sel_val = (rel_eff == REL_AUX) ? i_aux_reference_value : i_main_reference_value;
    pid_mode = 1'b0;
    case (rel_eff)
      REL_MAIN, REL_AUX: begin
        if ((rel_eff == REL_AUX) ? a_dig : m_dig) begin
          raw = trimmed(preset_f, i_updown_trim, upper_f, lower_f);
        end else if (sel_pid) begin
          pid_mode = 1'b1;
          raw = clampf(sel_val, pid_lo_eff, i_pid_upper_limit);
        end else begin
          raw = sel_val;
        end
      end
      default: raw = op_val;
    endcase
    if (raw > upper_f) raw = upper_f;
    if (raw < -upper_f) raw = -upper_f;
    mag = absf(raw);
    target_next = raw;
    below_next = 1'b0;
    stop_next = 1'b0;
    if (!pid_mode && mag < lower_f) begin
      below_next = 1'b1;
      case (params_reg.below_limit_action)
        ACT_STOP: begin
          target_next = '0;
          stop_next = 1'b1;
        end
        ACT_ZERO: target_next = '0;
        default: target_next = (raw < 0) ? -lower_f : lower_f;
      endcase
    end
    upper_next = frc_word_t'(upper_f);
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      target_reg <= '0;
      upper_reg <= RST_UPPER;
      below_reg <= 1'b0;
      stop_reg <= 1'b0;
    end else begin
      target_reg <= target_next;
      upper_reg <= upper_next;
      below_reg <= below_next;
      stop_reg <= stop_next;
    end
  end

  assign o_target_frequency = target_reg;
  assign o_upper_limit_active = upper_reg;
  assign o_below_lower = below_reg;
  assign o_stop_request = stop_reg;
  assign o_param_rdata = rdata_reg;
  assign o_param_reject = reject_reg;

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);

  chk_target_in_upper: assert property (absf(o_target_frequency) <= tof(o_upper_limit_active))
    else $error("Target exceeds active upper limit");
  chk_max_freq_range: assert property (params_reg.maximum_output_frequency >= MAX_FREQ_LO &&
    params_reg.maximum_output_frequency <= MAX_FREQ_HI)
    else $error("Maximum frequency out of range");
  chk_limit_order: assert property (params_reg.lower_limit_value <= params_reg.upper_limit_value &&
    params_reg.upper_limit_value <= params_reg.maximum_output_frequency)
    else $error("Limits out of order");
  chk_pct_coef_range: assert property (params_reg.aux_range_percent <= PCT_HI &&
    params_reg.main_multiply_coefficient <= COEF_HI)
    else $error("Percent or coefficient out of range");
  chk_stop_zero: assert property (o_stop_request |-> o_target_frequency == 18'sh00000 && o_below_lower &&
    $past(params_reg.below_limit_action) == ACT_STOP)
    else $error("Stop action without zero output");
  chk_below_run_lower: assert property (o_below_lower && $past(params_reg.below_limit_action) == ACT_RUN_LOWER
    |-> absf(o_target_frequency) == tof($past(params_reg.lower_limit_value)))
    else $error("Below-limit run not at lower limit");
  chk_pid_floor: assert property (i_relationship_select == REL_MAIN && i_main_source == SRC_PID &&
    i_reverse_prohibit |=> o_target_frequency >= 0 && !o_below_lower)
    else $error("PID output reversed while prohibited");
  chk_reject_bad_code: assert property (i_param_wr && i_param_idx == IDX_BELOW_ACT && i_param_wdata > ACT_ZERO
    |=> o_param_reject && $stable(params_reg.below_limit_action))
    else $error("Bad action code not rejected");
  chk_reset_max: assert property ($fell(i_rst) |-> params_reg.maximum_output_frequency == RST_MAX)
    else $error("Maximum frequency reset value wrong");

  cov_below_stop: cover property (o_stop_request);
  cov_op_mul: cover property (i_relationship_select == REL_OP && i_operation == OP_MUL && !m_bad && !a_bad);
  cov_add_pid_main: cover property (i_relationship_select == REL_OP && i_operation == OP_ADD && m_pid);
  cov_analog_upper: cover property (params_reg.upper_limit_source_select == ULS_AI_ONE);
endmodule

/* frc_combiner_bench.sv */
// Self-checking bench for the frequency reference combiner
`timescale 1ns/1ps
module frc_combiner_bench import frc_pkg::*;;
  logic i_clock, i_rst, wr, revp;
  frc_idx_t idx;
  frc_word_t wdata, ai1, ai2, ai3, comm, multi, ulim, rdata;
  frc_rel_t rel;
  logic [1:0] sw;
  frc_op_t op;
  frc_code_t msrc, asrc;
  frc_freq_t mref, aref, trim, pidhi, pidlo, tgt;
  logic below, stop, rej;
  int fails, n_checks;

  frc_combiner dut_u (.i_clock(i_clock), .i_rst(i_rst), .i_param_wr(wr), .i_param_idx(idx),
    .i_param_wdata(wdata), .i_relationship_select(rel), .i_switch_select(sw), .i_operation(op),
    .i_main_source(msrc), .i_aux_source(asrc), .i_main_reference_value(mref),
    .i_aux_reference_value(aref), .i_updown_trim(trim), .i_pid_upper_limit(pidhi),
    .i_pid_lower_limit(pidlo), .i_reverse_prohibit(revp), .i_analog_input_one(ai1),
    .i_analog_input_two(ai2), .i_analog_input_three(ai3), .i_comm_upper_limit(comm),
    .i_multi_upper_limit(multi), .o_target_frequency(tgt), .o_upper_limit_active(ulim),
    .o_below_lower(below), .o_stop_request(stop), .o_param_rdata(rdata), .o_param_reject(rej));

  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end

  task automatic results();
    if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read at the edge, before that edge's register updates land; inputs then move on the same edge
  task automatic tick(input int n);
    repeat (n) @(posedge i_clock);
  endtask

  task automatic wr_p(input frc_idx_t i, input frc_word_t d, input logic rj);
    @(posedge i_clock);
    wr <= 1'b1;
    idx <= i;
    wdata <= d;
    @(posedge i_clock);
    wr <= 1'b0;
    @(posedge i_clock);
    chk("reject", {17'h0, rej}, {17'h0, rj});
  endtask

  task automatic rd_p(input frc_idx_t i, input frc_word_t e);
    @(posedge i_clock);
    idx <= i;
    tick(3);
    chk("param", {2'h0, rdata}, {2'h0, e});
  endtask

  // One edge to sample, one spare so the registered output has settled
  task automatic dp(input string what, input frc_freq_t e);
    tick(2);
    chk(what, tgt, e);
  endtask

  task automatic t_reset();
    frc_word_t exp_v [11];
    exp_v = '{16'h0000, 16'h0064, 16'h03e8, 16'h03e8, 16'h1388, 16'h0000, 16'h1388, 16'h0000,
              16'h0000, 16'h0000, 16'h0000};
    for (int k = 0; k < 11; k++) rd_p(frc_idx_t'(k), exp_v[k]);
    rd_p(4'hb, 16'h0000);
    chk("upper", {2'h0, ulim}, 18'h01388);
  endtask

  task automatic t_reject();
    wr_p(IDX_AUX_BASE, 16'h0002, 1'b1);
    wr_p(IDX_BELOW_ACT, 16'h0003, 1'b1);
    wr_p(IDX_UPPER_SRC, 16'h0004, 1'b1);
    wr_p(4'hb, 16'h0001, 1'b1);
    rd_p(IDX_AUX_BASE, 16'h0000);
    rd_p(IDX_BELOW_ACT, 16'h0000);
    rd_p(IDX_UPPER_SRC, 16'h0000);
  endtask

  task automatic t_clamp();
    wr_p(IDX_MAX_FREQ, 16'hffff, 1'b0);
    rd_p(IDX_MAX_FREQ, 16'hea60);
    wr_p(IDX_MAX_FREQ, 16'h0000, 1'b0);
    rd_p(IDX_MAX_FREQ, 16'h1388);
    wr_p(IDX_AUX_PCT, 16'h00c8, 1'b0);
    rd_p(IDX_AUX_PCT, 16'h0096);
    wr_p(IDX_MAIN_COEF, 16'h3000, 1'b0);
    rd_p(IDX_MAIN_COEF, 16'h2710);
    wr_p(IDX_LOWER_VAL, 16'h1770, 1'b0);
    rd_p(IDX_LOWER_VAL, 16'h1388);
    wr_p(IDX_LOWER_VAL, 16'h0000, 1'b0);
  endtask

  task automatic t_digital();
    wr_p(IDX_PRESET, 16'h03e8, 1'b0);
    rel <= REL_MAIN;
    msrc <= SRC_DIG_VOLATILE;
    trim <= 18'sh001f4;
    dp("single digital", 18'sh005dc);
    trim <= 18'sh01388;
    dp("trim upper", 18'sh01388);
    trim <= -18'sh007d0;
    dp("trim sign", 18'sh00000);
  endtask

  task automatic t_pid();
    msrc <= SRC_PID;
    mref <= -18'sh0012c;
    pidlo <= -18'sh003e8;
    pidhi <= 18'sh00fa0;
    revp <= 1'b1;
    dp("pid no reverse", 18'sh00000);
    revp <= 1'b0;
    dp("pid reverse", -18'sh0012c);
    wr_p(IDX_LOWER_VAL, 16'h03e8, 1'b0);
    mref <= 18'sh000c8;
    pidlo <= 18'sh00000;
    dp("pid under lower", 18'sh000c8);
    chk("pid below", {17'h0, below}, 18'h0);
    mref <= 18'sh01194;
    dp("pid upper", 18'sh00fa0);
  endtask

  task automatic t_below();
    msrc <= 4'h2;
    mref <= 18'sh0012c;
    dp("run lower", 18'sh003e8);
    chk("below", {17'h0, below}, 18'h1);
    wr_p(IDX_BELOW_ACT, ACT_STOP, 1'b0);
    tick(2);
    chk("stop", {17'h0, stop}, 18'h1);
    wr_p(IDX_BELOW_ACT, ACT_ZERO, 1'b0);
    dp("zero speed", 18'sh00000);
    chk("stop off", {17'h0, stop}, 18'h0);
    wr_p(IDX_BELOW_ACT, ACT_RUN_LOWER, 1'b0);
    wr_p(IDX_LOWER_VAL, 16'h0000, 1'b0);
  endtask

  task automatic t_ops();
    rel <= REL_OP;
    op <= OP_ADD;
    msrc <= SRC_PID;
    mref <= 18'sh00384;
    asrc <= 4'h2;
    aref <= 18'sh00320;
    trim <= 18'sh001f4;
    dp("add pid main", 18'sh00320);
    op <= OP_SUB;
    msrc <= SRC_DIG_RETAIN;
    aref <= 18'sh0012c;
    dp("sub digital", 18'sh002bc);
    asrc <= SRC_DIG_VOLATILE;
    trim <= 18'sh000c8;
    dp("sub both digital", 18'sh004b0);
    op <= OP_MAX;
    msrc <= SRC_PLC;
    mref <= 18'sh00bb8;
    asrc <= 4'h2;
    aref <= 18'sh002bc;
    dp("max plc", 18'sh002bc);
    op <= OP_MIN;
    msrc <= 4'h2;
    mref <= 18'sh005dc;
    asrc <= SRC_PID;
    aref <= 18'sh00064;
    dp("min pid", 18'sh005dc);
    wr_p(IDX_AUX_COEF, COEF_HI, 1'b0);
    op <= OP_MUL;
    asrc <= 4'h3;
    mref <= 18'sh00fa0;
    aref <= 18'sh009c4;
    dp("multiply", 18'sh007d0);
  endtask

  task automatic t_range();
    wr_p(IDX_AUX_PCT, 16'h0032, 1'b0);
    op <= OP_ADD;
    mref <= 18'sh003e8;
    aref <= 18'sh00fa0;
    dp("range max", 18'sh00dac);
    wr_p(IDX_AUX_BASE, 16'h0001, 1'b0);
    dp("range main", 18'sh005dc);
    op <= OP_SUB;
    dp("range sub", -18'sh00bb8);
  endtask

  task automatic t_upper();
    frc_word_t src_v [6];
    frc_word_t exp_v [6];
    src_v = '{ULS_AI_ONE, ULS_AI_TWO, ULS_AI_THREE, ULS_COMM, ULS_MULTI, ULS_STORED};
    exp_v = '{16'h0c80, 16'h0898, 16'h04b0, 16'h0fa0, 16'h09c4, 16'h1388};
    ai1 <= 16'h0bb8;
    ai2 <= 16'h07d0;
    ai3 <= 16'h03e8;
    comm <= 16'h0fa0;
    multi <= 16'h09c4;
    wr_p(IDX_UPPER_OFS, 16'h00c8, 1'b0);
    for (int k = 0; k < 6; k++) begin
      wr_p(IDX_UPPER_SRC, src_v[k], 1'b0);
      tick(2);
      chk("upper active", {2'h0, ulim}, {2'h0, exp_v[k]});
    end
  endtask

  task automatic t_switch();
    msrc <= 4'h2;
    mref <= 18'sh00258;
    asrc <= 4'h2;
    aref <= 18'sh004b0;
    rel <= REL_AUX;
    dp("aux only", 18'sh004b0);
    rel <= REL_SWITCH;
    sw <= 2'h1;
    dp("switch aux", 18'sh004b0);
    sw <= 2'h0;
    dp("switch main", 18'sh00258);
    rel <= REL_OP;
    op <= OP_ADD;
    asrc <= SRC_DIG_VOLATILE;
    mref <= -18'sh003e8;
    trim <= 18'sh007d0;
    dp("trim no reverse", 18'sh00000);
  endtask

  // Guards against a stalled run
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    results();
  end

  initial begin
    fails = 0;
    n_checks = 0;
    i_rst = 1'b1;
    {wr, revp, idx, wdata, ai1, ai2, ai3, comm, multi, sw, msrc, asrc} = '0;
    {mref, aref, trim, pidhi, pidlo} = '0;
    rel = REL_MAIN;
    op = OP_ADD;
    repeat (12) @(posedge i_clock);
    i_rst <= 1'b0;
    tick(1);
    t_reset();
    t_reject();
    t_clamp();
    t_digital();
    t_pid();
    t_below();
    t_ops();
    t_range();
    t_upper();
    t_switch();
    results();
  end
endmodule
